/* File: design/rpe_params.svh */
// Purpose: offsets, fields, resets and timing for the packet engine regs
// Assumes: 200 MHz system clock
// Notes:   byte-wide registers at their printed addresses
`ifndef RPE_PARAMS_SVH
`define RPE_PARAMS_SVH
`define RPE_OFF_STATUS    16'h103e
`define RPE_OFF_ACKCTL    16'h103f
`define RPE_OFF_SEED      16'h1040
`define RPE_OFF_DELAY     16'h1041
`define RPE_OFF_CRCWHT    16'h1042
`define RPE_OFF_CBLEN     16'h1043
`define RPE_OFF_ACKLEN    16'h1044
`define RPE_OFF_SETTLE    16'h1045
`define RPE_OFF_DCOUT     16'h1046
`define RPE_OFF_LOOPF     16'h1047
`define RPE_OFF_AUX       16'h1048
`define RPE_OFF_WAKE      16'h1049
`define RPE_OFF_INBAND_DETECT_THRESHOLD      16'h104c
`define RPE_OFF_CDSEL     16'h104d
`define RPE_OFF_RXTOL     16'h104f
`define RPE_OFF_RXDEM     16'h1050
`define RPE_OFF_DCAVG     16'h1051
`define RPE_OFF_DCMODE    16'h1052
`define RPE_RESET_BYTE    8'h00
`define RPE_ACK_EN_BIT    0
`define RPE_ARC_LSB       1
`define RPE_ARC_MSB       4
`define RPE_INTERVAL_BIT  5
`define RPE_PW_BIT        6
`define RPE_VMODE_BIT     7
`define RPE_DCSEL_BIT     0
`define RPE_ACKFIFO_BIT   1
`define RPE_CRCM_LSB      3
`define RPE_CRCM_MSB      4
`define RPE_CCITT_BIT     5
`define RPE_NINE_BIT_WHITENING_ENABLE_BIT      6
`define RPE_DYNLEN_BIT    6
`define RPE_CBEN_BIT      7
`define RPE_WHOLD_BIT     0
`define RPE_WRST_BIT      1
`define RPE_CDSEL_BIT     0
`define RPE_ETH_MSB       2
`define RPE_DCM_MSB       1
`define RPE_CCITT_INIT0   16'h1d0f
`define RPE_CCITT_INIT1   16'hffff
`define RPE_OTHER_INIT    16'h0000
`define RPE_PN9_SEED      9'h1ff
`define RPE_CLK_NS        5
`define RPE_PULSE_SHORT_NS 10000
`define RPE_PULSE_LONG_NS 30000
`define RPE_STEP_NS       200000
`define RPE_PULSE_SHORT_CYC \
  ((`RPE_PULSE_SHORT_NS + `RPE_CLK_NS - 1) / `RPE_CLK_NS)
`define RPE_PULSE_LONG_CYC \
  ((`RPE_PULSE_LONG_NS + `RPE_CLK_NS - 1) / `RPE_CLK_NS)
`define RPE_STEP_CYC ((`RPE_STEP_NS + `RPE_CLK_NS - 1) / `RPE_CLK_NS)
`endif

/* File: design/rpe_pkg.sv */
// Purpose: types shared by the packet engine register block
// Assumes: nothing beyond the params header
// Notes:   constants live in rpe_params.svh
package rpe_pkg;
  typedef enum logic [2:0] {
    RPE_RS_IDLE = 3'b001,
    RPE_RS_WAIT = 3'b010,
    RPE_RS_DONE = 3'b100
  } rpe_resend_type;
  typedef enum logic [1:0] {
    RPE_CRC_CCITT = 2'h0,
    RPE_CRC_DNP   = 2'h1,
    RPE_CRC_IBM   = 2'h2,
    RPE_CRC_8     = 2'h3
  } rpe_crc_type;
endpackage

/* File: design/rpe_regs.sv */
// Purpose: packet engine configuration, resend timing and status
// Assumes: radio events are one-cycle pulses synchronous to clk_sys
// Notes:   reads return data in the cycle after the read strobe
`include "rpe_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rpe_regs #(
  parameter int STEP_CYC = `RPE_STEP_CYC,
  parameter int PLONG_CYC = `RPE_PULSE_LONG_CYC,
  parameter int PSHORT_CYC = `RPE_PULSE_SHORT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        tx_mode,
  input  wire logic        tx_start,
  input  wire logic        ack_ok,
  input  wire logic        packet_valid,
  input  wire logic        strobe_cmd,
  input  wire logic        packet_end,
  input  wire logic        wake_event,
  input  wire logic        carrier_in,
  input  wire logic        preamble_ok,
  input  wire logic [7:0]  rssi,
  input  wire logic [7:0]  auto_threshold,
  input  wire logic [3:0]  id_err_count,
  input  wire logic        frame_sync,
  input  wire logic [7:0]  dc_estimate,
  input  wire logic        whiten_step,
  input  wire logic [7:0]  tx_ctrl_in,
  input  wire logic        tx_ctrl_load,
  input  wire logic [7:0]  rx_ctrl_in,
  input  wire logic        rx_ctrl_load,
  input  wire logic [13:0] rx_len_in,
  input  wire logic        rx_len_load,
  output logic [7:0]       reg_rdata,
  output logic             resend_req,
  output logic             auto_ack_en,
  output logic             valid_ind,
  output logic [15:0]      crc_init,
  output logic [1:0]       crc_mode,
  output logic             whiten_bit,
  output logic             ack_fifo_sel,
  output logic [7:0]       ack_payload_length,
  output logic             control_byte_enable,
  output logic [7:0]       dc_ref,
  output logic             timed_wakeup_signal,
  output logic             hold_rx,
  output logic             carrier_detect,
  output logic             id_match
);
  logic [7:0] ackctl_q, seed_q, delay_q, crcwht_q, cblen_q;
  logic [7:0] acklen_q, settle_q, loopf_q, aux_q, wake_q;
  logic [7:0] inband_detect_threshold_q, cdsel_q, rxtol_q, rxdem_q, dcavg_q;
  logic [7:0] dcmode_q;
  logic [7:0] tx_ctrl_q, rx_ctrl_q, dc_sync_q, rdata_q;
  logic [13:0] rx_len_q;
  logic [3:0] countdown_q;
  logic finished_q, vflag_q, resend_req_q;
  logic [7:0] lfsr_q;
  logic [8:0] pn9_q;
  logic [15:0] tick_q;
  logic [8:0] steps_q;
  logic [15:0] pulse_q;
  logic valid_ind_q, wake_sig_q, hold_q, cd_q, idm_q, auto_ack_q;
  logic [7:0] dc_ref_q;
  logic [15:0] crc_init_q;
  rpe_pkg::rpe_resend_type rs_q;

  // field views of the control bytes
  logic       ack_en;
  logic [3:0] resend_cycle_setting;
  logic       fixed_iv;
  logic       vpulse;
  logic       long_pw;
  logic       ev_valid;
  logic       seq_go;
  assign ack_en   = ackctl_q[`RPE_ACK_EN_BIT];
  assign resend_cycle_setting      = ackctl_q[`RPE_ARC_MSB:`RPE_ARC_LSB];
  assign fixed_iv = ackctl_q[`RPE_INTERVAL_BIT];
  assign long_pw  = ackctl_q[`RPE_PW_BIT];
  assign vpulse   = ackctl_q[`RPE_VMODE_BIT];
  assign ev_valid = packet_valid | ack_ok;
  assign seq_go   = tx_start & tx_mode & ack_en & (resend_cycle_setting != 4'h0);

  // address decode for the read mux only; the write side decodes separately
  function automatic logic [7:0] rd_mux(input logic [15:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == `RPE_OFF_STATUS) begin
      r = {2'h0, finished_q, vflag_q, countdown_q};
    end else if (a == `RPE_OFF_ACKCTL) begin
      r = ackctl_q;
    end else if (a == `RPE_OFF_SEED) begin
      r = seed_q;
    end else if (a == `RPE_OFF_DELAY) begin
      r = delay_q;
    end else if (a == `RPE_OFF_CRCWHT) begin
      r = tx_ctrl_q;
    end else if (a == `RPE_OFF_CBLEN) begin
      r = rx_ctrl_q;
    end else if (a == `RPE_OFF_ACKLEN) begin
      r = {2'h0, rx_len_q[13:8]};
    end else if (a == `RPE_OFF_SETTLE) begin
      r = rx_len_q[7:0];
    end else if (a == `RPE_OFF_DCOUT) begin
      r = dc_ref_q;
    end
    return r;
  endfunction

  // write side: every writable byte, reset to zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ackctl_q <= `RPE_RESET_BYTE;
      seed_q   <= `RPE_RESET_BYTE;
      delay_q  <= `RPE_RESET_BYTE;
      crcwht_q <= `RPE_RESET_BYTE;
      cblen_q  <= `RPE_RESET_BYTE;
      acklen_q <= `RPE_RESET_BYTE;
      settle_q <= `RPE_RESET_BYTE;
      loopf_q  <= `RPE_RESET_BYTE;
      aux_q    <= `RPE_RESET_BYTE;
      wake_q   <= `RPE_RESET_BYTE;
      inband_detect_threshold_q   <= `RPE_RESET_BYTE;
      cdsel_q  <= `RPE_RESET_BYTE;
      rxtol_q  <= `RPE_RESET_BYTE;
      rxdem_q  <= `RPE_RESET_BYTE;
      dcavg_q  <= `RPE_RESET_BYTE;
      dcmode_q <= `RPE_RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `RPE_OFF_ACKCTL) begin
        ackctl_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_SEED) begin
        seed_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_DELAY) begin
        delay_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_CRCWHT) begin
        crcwht_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_CBLEN) begin
        cblen_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_ACKLEN) begin
        acklen_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_SETTLE) begin
        settle_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_LOOPF) begin
        loopf_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_AUX) begin
        aux_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_WAKE) begin
        wake_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_INBAND_DETECT_THRESHOLD) begin
        inband_detect_threshold_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_CDSEL) begin
        cdsel_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_RXTOL) begin
        rxtol_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_RXDEM) begin
        rxdem_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_DCAVG) begin
        dcavg_q <= reg_wdata;
      end else if (reg_addr == `RPE_OFF_DCMODE) begin
        dcmode_q <= reg_wdata;
      end
    end
  end

  // read data stands for exactly one cycle, zero otherwise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux(reg_addr);
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // random source, reseeded whenever software writes the seed
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lfsr_q <= 8'h01;
    end else if (reg_wr && reg_addr == `RPE_OFF_SEED) begin
      lfsr_q <= (reg_wdata == 8'h00) ? 8'h01 : reg_wdata;
    end else begin
      lfsr_q <= {lfsr_q[6:0],
                 lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  // resend sequencer: wait a delay, fire, count down
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rs_q         <= rpe_pkg::RPE_RS_IDLE;
      countdown_q  <= 4'h0;
      finished_q   <= 1'b0;
      resend_req_q <= 1'b0;
      tick_q       <= 16'h0000;
      steps_q      <= 9'h000;
    end else begin
      resend_req_q <= 1'b0;
      case (rs_q)
        rpe_pkg::RPE_RS_IDLE: begin
          if (seq_go) begin
            countdown_q <= resend_cycle_setting;
            finished_q  <= 1'b0;
            tick_q      <= 16'h0000;
            // fixed uses full delay; random masks it by lfsr
            steps_q     <= fixed_iv ? {1'b0, delay_q} :
                           {1'b0, delay_q & lfsr_q};
            rs_q        <= rpe_pkg::RPE_RS_WAIT;
          end
        end
        rpe_pkg::RPE_RS_WAIT: begin
          if (ack_ok || !ack_en) begin
            // ack arrived or software pulled the enable
            finished_q <= 1'b1;
            rs_q       <= rpe_pkg::RPE_RS_DONE;
          end else if (tick_q != 16'(STEP_CYC - 1)) begin
            tick_q <= tick_q + 16'h0001;
          end else if (steps_q != 9'h000) begin
            tick_q  <= 16'h0000;
            steps_q <= steps_q - 9'h001;
          end else begin
            resend_req_q <= 1'b1;
            countdown_q  <= countdown_q - 4'h1;
            tick_q       <= 16'h0000;
            steps_q      <= fixed_iv ? {1'b0, delay_q} :
                            {1'b0, delay_q & lfsr_q};
            if (countdown_q == 4'h1) begin
              finished_q <= 1'b1;
              rs_q       <= rpe_pkg::RPE_RS_DONE;
            end
          end
        end
        rpe_pkg::RPE_RS_DONE: begin
          if (seq_go) begin
            countdown_q <= resend_cycle_setting;
            finished_q  <= 1'b0;
            tick_q      <= 16'h0000;
            steps_q     <= fixed_iv ? {1'b0, delay_q} :
                           {1'b0, delay_q & lfsr_q};
            rs_q        <= rpe_pkg::RPE_RS_WAIT;
          end
        end
        default: begin
          rs_q <= rpe_pkg::RPE_RS_IDLE;
        end
      endcase
    end
  end

  // sticky valid-or-ack flag; a new event beats the strobe clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vflag_q <= 1'b0;
    end else if (ev_valid) begin
      vflag_q <= 1'b1;
    end else if (strobe_cmd) begin
      vflag_q <= 1'b0;
    end
  end

  // valid indication: level follows flag, or a timed pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      valid_ind_q <= 1'b0;
      pulse_q     <= 16'h0000;
    end else if (!vpulse) begin
      pulse_q     <= 16'h0000;
      valid_ind_q <= ev_valid | (vflag_q & ~strobe_cmd);
    end else if (ev_valid && pulse_q == 16'h0000) begin
      // width counted from this edge, so high exactly N cycles
      pulse_q     <= long_pw ? 16'(PLONG_CYC - 1) :
                     16'(PSHORT_CYC - 1);
      valid_ind_q <= 1'b1;
    end else if (pulse_q != 16'h0000) begin
      pulse_q <= pulse_q - 16'h0001;
    end else begin
      valid_ind_q <= 1'b0;
    end
  end

  // checksum selection and its start value
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      crc_init_q <= `RPE_CCITT_INIT0;
    end else if (crcwht_q[`RPE_CRCM_MSB:`RPE_CRCM_LSB] ==
                 rpe_pkg::RPE_CRC_CCITT) begin
      crc_init_q <= crcwht_q[`RPE_CCITT_BIT] ?
                    `RPE_CCITT_INIT1 : `RPE_CCITT_INIT0;
    end else begin
      crc_init_q <= `RPE_OTHER_INIT;
    end
  end

  // pn9 whitening, restarted with every packet
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pn9_q <= `RPE_PN9_SEED;
    end else if (tx_start) begin
      pn9_q <= `RPE_PN9_SEED;
    end else if (whiten_step && crcwht_q[`RPE_NINE_BIT_WHITENING_ENABLE_BIT]) begin
      pn9_q <= {pn9_q[7:0], pn9_q[8] ^ pn9_q[4]};
    end
  end

  // control bytes and received length capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_ctrl_q <= 8'h00;
      rx_ctrl_q <= 8'h00;
      rx_len_q  <= 14'h0000;
    end else begin
      if (tx_ctrl_load && cblen_q[`RPE_CBEN_BIT]) begin
        tx_ctrl_q <= tx_ctrl_in;
      end
      if (rx_ctrl_load) begin
        rx_ctrl_q <= rx_ctrl_in;
      end
      if (rx_len_load && cblen_q[`RPE_DYNLEN_BIT]) begin
        rx_len_q <= rx_len_in;
      end
    end
  end

  // wake-on-receive signal and receive hold
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wake_sig_q <= 1'b0;
      hold_q     <= 1'b0;
    end else begin
      if (wake_event) begin
        wake_sig_q <= 1'b1;
      end else if (wake_q[`RPE_WRST_BIT] ? strobe_cmd :
                   packet_end) begin
        wake_sig_q <= 1'b0;
      end
      if (wake_q[`RPE_WHOLD_BIT] && (carrier_in || preamble_ok)) begin
        hold_q <= 1'b1;
      end else if (strobe_cmd || packet_end ||
                   !wake_q[`RPE_WHOLD_BIT]) begin
        hold_q <= 1'b0;
      end
    end
  end

  // carrier compare, id tolerance and dc reference
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cd_q      <= 1'b0;
      idm_q     <= 1'b0;
      dc_sync_q <= 8'h00;
      dc_ref_q  <= 8'h00;
    end else begin
      cd_q  <= cdsel_q[`RPE_CDSEL_BIT] ? (rssi >= inband_detect_threshold_q) :
               (rssi >= auto_threshold);
      idm_q <= id_err_count <= {1'b0, rxtol_q[`RPE_ETH_MSB:0]};
      if (frame_sync) begin
        dc_sync_q <= dc_estimate;
      end
      // software value is ignored unless estimation mode is 00
      if (crcwht_q[`RPE_DCSEL_BIT] &&
          dcmode_q[`RPE_DCM_MSB:0] == 2'h0) begin
        dc_ref_q <= dcavg_q;
      end else begin
        dc_ref_q <= dc_sync_q;
      end
    end
  end

  // registered outputs
  assign reg_rdata           = rdata_q;
  assign resend_req          = resend_req_q;
  assign auto_ack_en         = auto_ack_q;
  assign valid_ind           = valid_ind_q;
  assign crc_init            = crc_init_q;
  assign crc_mode            = crcwht_q[`RPE_CRCM_MSB:`RPE_CRCM_LSB];
  assign whiten_bit          = pn9_q[8];
  assign ack_fifo_sel        = crcwht_q[`RPE_ACKFIFO_BIT];
  assign ack_payload_length  = acklen_q;
  assign control_byte_enable = cblen_q[`RPE_CBEN_BIT];
  assign dc_ref              = dc_ref_q;
  assign timed_wakeup_signal = wake_sig_q;
  assign hold_rx             = hold_q;
  assign carrier_detect      = cd_q;
  assign id_match            = idm_q;

  // auto-ack only while receiving; lags enable and direction a cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      auto_ack_q <= 1'b0;
    end else begin
      auto_ack_q <= ack_en & ~tx_mode;
    end
  end
endmodule
`default_nettype wire

/* File: tb/rpe_far_node.sv */
// Purpose: far radio node that answers resends with an acknowledgement
// Assumes: resend_req is a one-cycle pulse on clk_sys
// Notes:   answer low leaves every resend unanswered
`timescale 1ns/1ps
`default_nettype none
module rpe_far_node (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic resend_req,
  input  wire logic answer,
  output logic      ack_ok
);
  logic [1:0] dly_q;
  // ack comes back two cycles later, standing in for air time
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) dly_q <= 2'h0;
    else dly_q <= {dly_q[0], resend_req & answer};
  end
  assign ack_ok = dly_q[1];
endmodule
`default_nettype wire

/* File: tb/rpe_regs_props.sv */
// Purpose: port-level checks of the packet engine register block
// Assumes: one clk_sys domain, rstn asynchronous and active low
// Notes:   gap helper saturates so long idle stretches never wrap
`timescale 1ns/1ps
`default_nettype none
module rpe_regs_props #(
  parameter int STEP_CYC = 4
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        tx_mode,
  input wire logic        resend_req,
  input wire logic        auto_ack_en,
  input wire logic        packet_valid,
  input wire logic        valid_ind,
  input wire logic [15:0] crc_init,
  input wire logic [1:0]  crc_mode,
  input wire logic        wake_event,
  input wire logic        timed_wakeup_signal,
  input wire logic        strobe_cmd,
  input wire logic        carrier_in,
  input wire logic        preamble_ok,
  input wire logic        hold_rx,
  input wire logic [3:0]  id_err_count,
  input wire logic        id_match
);
  logic [15:0] gap_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // cycles since the last resend, saturating
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) gap_q <= 16'hffff;
    else if (resend_req) gap_q <= 16'h0001;
    else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
  end
  a_read_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_wo_reads_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == 16'h104c |-> reg_rdata == 8'h00)
    else $error("write-only threshold read back");
  a_ack_rx_only: assert property (
    auto_ack_en |-> !$past(tx_mode))
    else $error("auto ack while transmitting");
  a_crc_other_zero: assert property (
    $past(crc_mode) != 2'h0 |-> crc_init == 16'h0000)
    else $error("non ccitt init not zero");
  a_resend_gap: assert property (
    resend_req |-> gap_q >= STEP_CYC)
    else $error("resends closer than one step");
  a_valid_rise: assert property (
    packet_valid && !valid_ind |=> valid_ind)
    else $error("valid indication missed");
  a_wake_set: assert property (
    wake_event |=> timed_wakeup_signal)
    else $error("wake signal not set");
  a_hold_drop: assert property (
    strobe_cmd && !carrier_in && !preamble_ok |=> !hold_rx)
    else $error("hold stayed after strobe");
  a_id_exact: assert property (
    $past(rstn) && $past(id_err_count) == 4'h0 |-> id_match)
    else $error("error-free id rejected");
  c_resend_pair: cover property (resend_req ##8 resend_req);
  c_valid_end: cover property ($fell(valid_ind));
  c_wake_strobe: cover property (timed_wakeup_signal && strobe_cmd);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the packet engine register block
// Assumes: short step and pulse counts set by parameter
// Notes:   far node model supplies acknowledgements
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int STEP_CYC = 4;
  logic        clk_sys, rstn, reg_wr, reg_rd, tx_mode, ack_ok, answer;
  logic        tx_start, packet_valid, strobe_cmd, packet_end, wake_event;
  logic        carrier_in, frame_sync, preamble_ok, whiten_step;
  logic        tx_ctrl_load, rx_ctrl_load, rx_len_load, resend_req;
  logic        auto_ack_en, valid_ind, whiten_bit, ack_fifo_sel, hold_rx;
  logic        control_byte_enable, timed_wakeup_signal, carrier_detect;
  logic        id_match;
  logic [15:0] reg_addr, crc_init;
  logic [13:0] rx_len_in;
  logic [7:0]  reg_wdata, reg_rdata, rssi, auto_threshold, dc_estimate;
  logic [7:0]  tx_ctrl_in, rx_ctrl_in, ack_payload_length, dc_ref;
  logic [6:0]  ev;
  logic [3:0]  id_err_count;
  logic [1:0]  crc_mode;
  int          bad_count, samples_checked, cyc, k;
  // event bits: 0 start 1 valid 2 strobe 3 end 4 wake 5 carrier 6 sync
  assign {frame_sync, carrier_in, wake_event, packet_end} = ev[6:3];
  assign {strobe_cmd, packet_valid, tx_start} = ev[2:0];
  rpe_regs #(.STEP_CYC(STEP_CYC), .PLONG_CYC(6), .PSHORT_CYC(2)) rpe_regs_inst (
    .clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .tx_mode,
    .tx_start, .ack_ok, .packet_valid, .strobe_cmd, .packet_end,
    .wake_event, .carrier_in, .preamble_ok, .rssi, .auto_threshold,
    .id_err_count, .frame_sync, .dc_estimate, .whiten_step, .tx_ctrl_in,
    .tx_ctrl_load, .rx_ctrl_in, .rx_ctrl_load, .rx_len_in, .rx_len_load,
    .reg_rdata, .resend_req, .auto_ack_en, .valid_ind, .crc_init,
    .crc_mode, .whiten_bit, .ack_fifo_sel, .ack_payload_length,
    .control_byte_enable, .dc_ref, .timed_wakeup_signal, .hold_rx,
    .carrier_detect, .id_match);
  rpe_far_node rpe_far_node_inst (.clk_sys, .rstn, .resend_req, .answer,
    .ack_ok);
  // free-running clock at 200 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      complete_run;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic pul(input int b);
    @(posedge clk_sys);
    ev <= 7'h01 << b;
    @(posedge clk_sys);
    ev <= 7'h00;
  endtask
  // bounded wait for the next resend pulse, edges counted in k
  task automatic wait_req(input int lim);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (resend_req !== 1'b1 && k < lim);
  endtask
  task automatic start_seq(input logic [7:0] cfg, input logic [7:0] dl);
    wr(16'h1041, dl);
    wr(16'h103f, cfg);
    pul(2);
    pul(0);
  endtask
  task automatic t_reset;
    rd(16'h103e, 8'h00);
    rd(16'h103f, 8'h00);
    rd(16'h1041, 8'h00);
    rd(16'h104a, 8'h00);
    rd(16'h104c, 8'h00);
    chk(crc_init, 16'h1d0f);
    chk(whiten_bit, 1'b1);
  endtask
  task automatic t_regs;
    wr(16'h1040, 8'ha5);
    rd(16'h1040, 8'ha5);
    wr(16'h1042, 8'h02);
    wr(16'h1044, 8'h33);
    wr(16'h1043, 8'hc0);
    tk(2);
    chk(ack_fifo_sel, 1'b1);
    chk(ack_payload_length, 8'h33);
    chk(control_byte_enable, 1'b1);
    @(posedge clk_sys);
    {tx_ctrl_in, rx_ctrl_in, rx_len_in} <= {8'h9a, 8'h6b, 14'h2abc};
    {tx_ctrl_load, rx_ctrl_load, rx_len_load} <= 3'h7;
    @(posedge clk_sys);
    {tx_ctrl_load, rx_ctrl_load, rx_len_load} <= 3'h0;
    rd(16'h1042, 8'h9a);
    rd(16'h1043, 8'h6b);
    rd(16'h1044, 8'h2a);
    rd(16'h1045, 8'hbc);
  endtask
  task automatic t_crc;
    for (int m = 0; m < 8; m++) begin
      wr(16'h1042, {2'h0, m[0], m[2:1], 3'h0});
      tk(2);
      chk(crc_mode, m[2:1]);
      chk(crc_init, m[2:1] != 0 ? 16'h0 : m[0] ? 16'hffff : 16'h1d0f);
    end
  endtask
  // fixed interval, two resends eight cycles (two steps) apart
  task automatic t_fixed;
    start_seq(8'h25, 8'h01);
    rd(16'h103e, 8'h02);
    wait_req(40);
    wait_req(40);
    chk(k, 8);
    rd(16'h103e, 8'h20);
    wait_req(40);
    chk(k, 40);
  endtask
  task automatic t_random;
    wr(16'h1040, 8'h5c);
    start_seq(8'h05, 8'h03);
    wait_req(40);
    wait_req(40);
    chk(k % 4 == 0 && k >= 4 && k <= 16, 1'b1);
  endtask
  // an answered resend ends the sequence early
  task automatic t_ack;
    answer = 1'b1;
    start_seq(8'h25, 8'h01);
    wait_req(40);
    tk(4);
    rd(16'h103e, 8'h31);
    wait_req(30);
    chk(k, 30);
    pul(2);
    rd(16'h103e, 8'h21);
    answer = 1'b0;
  endtask
  task automatic t_off;
    start_seq(8'h21, 8'h01);
    wait_req(30);
    chk(k, 30);
    start_seq(8'h24, 8'h01);
    wait_req(30);
    chk(k, 30);
  endtask
  task automatic t_valid;
    int n;
    for (int i = 0; i < 2; i++) begin
      wr(16'h103f, i ? 8'hc0 : 8'h80);
      pul(1);
      #1 n = 0;
      while (valid_ind === 1'b1 && n < 50) begin
        @(posedge clk_sys);
        #1 n++;
      end
      chk(n, i ? 6 : 2);
    end
    wr(16'h103f, 8'h00);
    pul(1);
    tk(20);
    chk(valid_ind, 1'b1);
    pul(2);
    tk(1);
    chk(valid_ind, 1'b0);
  endtask
  task automatic t_dc;
    @(posedge clk_sys) dc_estimate <= 8'h44;
    pul(6);
    tk(2);
    chk(dc_ref, 8'h44);
    wr(16'h1051, 8'h5a);
    wr(16'h1042, 8'h01);
    tk(2);
    chk(dc_ref, 8'h5a);
    rd(16'h1046, 8'h5a);
    wr(16'h1052, 8'h01);
    tk(2);
    chk(dc_ref, 8'h44);
  endtask
  task automatic t_wake;
    wr(16'h1049, 8'h02);
    pul(4);
    pul(3);
    tk(1);
    chk(timed_wakeup_signal, 1'b1);
    pul(2);
    tk(1);
    chk(timed_wakeup_signal, 1'b0);
    wr(16'h1049, 8'h00);
    pul(4);
    pul(3);
    tk(1);
    chk(timed_wakeup_signal, 1'b0);
    wr(16'h1049, 8'h01);
    pul(5);
    tk(1);
    chk(hold_rx, 1'b1);
    pul(2);
    tk(1);
    chk(hold_rx, 1'b0);
    wr(16'h1049, 8'h00);
    pul(5);
    tk(1);
    chk(hold_rx, 1'b0);
  endtask
  task automatic t_misc;
    wr(16'h104f, 8'h03);
    @(posedge clk_sys) id_err_count <= 4'h3;
    tk(2);
    chk(id_match, 1'b1);
    @(posedge clk_sys) id_err_count <= 4'h4;
    tk(2);
    chk(id_match, 1'b0);
    wr(16'h104c, 8'h40);
    wr(16'h104d, 8'h01);
    @(posedge clk_sys) {rssi, auto_threshold} <= {8'h50, 8'hff};
    tk(2);
    chk(carrier_detect, 1'b1);
    @(posedge clk_sys) rssi <= 8'h30;
    tk(2);
    chk(carrier_detect, 1'b0);
    wr(16'h104d, 8'h00);
    @(posedge clk_sys) rssi <= 8'h50;
    tk(2);
    chk(carrier_detect, 1'b0);
    wr(16'h103f, 8'h01);
    @(posedge clk_sys) tx_mode <= 1'b0;
    tk(2);
    chk(auto_ack_en, 1'b1);
    @(posedge clk_sys) tx_mode <= 1'b1;
    tk(2);
    chk(auto_ack_en, 1'b0);
    wr(16'h1042, 8'h40);
    @(posedge clk_sys) whiten_step <= 1'b1;
    tk(9);
    chk(whiten_bit, 1'b0);
    tk(5);
    chk(whiten_bit, 1'b1);
  endtask
  // reset, then every scenario in turn
  initial begin
    {rstn, reg_wr, reg_rd, tx_mode, answer, ev} = '0;
    {preamble_ok, whiten_step, tx_ctrl_load, rx_ctrl_load, rx_len_load} = '0;
    {reg_addr, reg_wdata, rssi, auto_threshold, dc_estimate} = '0;
    {tx_ctrl_in, rx_ctrl_in, rx_len_in, id_err_count} = '0;
    bad_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys) tx_mode <= 1'b1;
    t_reset;
    t_regs;
    t_crc;
    t_fixed;
    t_fixed;
    t_random;
    t_ack;
    t_off;
    t_valid;
    t_dc;
    t_wake;
    t_misc;
    complete_run;
  end
endmodule
bind rpe_regs rpe_regs_props #(.STEP_CYC(STEP_CYC)) rpe_regs_props_inst (
  .clk_sys, .rstn, .reg_addr, .reg_rd, .reg_rdata, .tx_mode, .resend_req,
  .auto_ack_en, .packet_valid, .valid_ind, .crc_init, .crc_mode,
  .wake_event, .timed_wakeup_signal, .strobe_cmd, .carrier_in,
  .preamble_ok, .hold_rx, .id_err_count, .id_match);
`default_nettype wire
